// file: dsp_iface.sv
// pin-level logic of a split-port ddr sram, plus its write fifo
// assumes: all pins, pin clocks included, are asynchronous to clk_i,
// which must run well above twice the pin clock rate
`timescale 1ns/100ps
`include "dsp_defines.svh"

// write staging fifo, flop storage
module dsp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = `DSP_FIFO_DEPTH
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // entries
    logic [PW-1:0]           wp;  // write index
    logic [PW-1:0]           rp;  // read index
    logic [PW:0]             cnt; // fill level
  } dsp_fifo_s;

  dsp_fifo_s s_q, s_d;
  logic      push, pop;

  // honest flags straight from the fill level
  assign in_ready_o  = (s_q.cnt != FULL);
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o  = s_q.mem[s_q.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // pointer and level update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data_i;
      s_d.wp          = PW'(s_q.wp + 1'h1);
    end
    if (pop) begin
      s_d.rp = PW'(s_q.rp + 1'h1);
    end
    s_d.cnt = (PW+1)'(s_q.cnt + push - pop);
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : dsp_fifo

// device top: pin sampling, arrays, read burst launch
module dsp_iface #(
  parameter int DW         = `DSP_DW,
  parameter int MEM_AW     = `DSP_MEM_AW,
  parameter int RD_LAT     = `DSP_RD_LAT,
  parameter int FIFO_DEPTH = `DSP_FIFO_DEPTH,
  parameter int NB         = DW / `DSP_LANE_W,
  // address pins follow data width
  parameter int AW = (DW == `DSP_DW_X9) ? `DSP_AW_X9 :
                     ((DW == `DSP_DW_X18) ? `DSP_AW_X18 : `DSP_AW_X36)
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          input_timing_pos_i,
  input  wire logic          input_timing_neg_i,
  input  wire logic          output_timing_pos_i,
  input  wire logic          output_timing_neg_i,
  input  wire logic          single_clk_mode_i,
  input  wire logic          pll_disable_n_i,
  input  wire logic          write_port_select_n_i,
  input  wire logic          read_port_select_n_i,
  input  wire logic [NB-1:0] byte_write_select_n_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] d_i,
  output logic      [DW-1:0] q_o,
  output logic               q_oe_o,
  output logic               echo_timing_o,
  output logic               wr_ready_o
);
  localparam int MD = 1 << MEM_AW;
  localparam int LW = (RD_LAT > 0) ? $clog2(RD_LAT + 1) : 1;
  localparam int LN = `DSP_LANE_W;
  localparam int EW = MEM_AW + 2 * (DW + NB);

  typedef struct packed {
    logic [1:0]              kp, kn, cp, cn; // pin clock syncs
    logic [1:0]              scm, pll;       // mode pin syncs
    logic [1:0]              write_port_select_n, read_port_select_n;       // select syncs
    logic                    kp_l, kn_l;     // last synced level
    logic                    cp_l, cn_l;
    logic [1:0][NB-1:0]      byte_write_select_n;            // mask sync
    logic [1:0][AW-1:0]      a;              // address sync
    logic [1:0][DW-1:0]      d;              // data sync
    logic                    wp;             // write beat0 held
    logic [DW-1:0]           wd0;            // first write beat
    logic [NB-1:0]           wm0;            // its mask
    logic [MD-1:0][DW-1:0]   mem0;           // first-beat array
    logic [MD-1:0][DW-1:0]   mem1;           // second-beat array
    logic                    rdp_v;          // read waiting
    logic [DW-1:0]           rd0, rd1;       // fetched burst
    logic [LW-1:0]           lat;            // launch delay left
    dsp_pkg::dsp_rd_e        st;             // output sequencer
    logic [DW-1:0]           hold1;          // second beat
    logic [DW-1:0]           q;              // data pins
    logic                    oe;             // data pin enable
    logic                    echo;           // echo clock
    logic                    wrdy;           // fifo has room
  } dsp_iface_s;

  dsp_iface_s      s_q, s_d;
  logic            k_rise, kn_rise, o_rise, on_rise;
  logic            rd_take, wr_start, push, drain, f_valid, f_ready;
  logic [EW-1:0]   f_in, f_out;
  logic [MEM_AW-1:0] f_idx, ra;
  logic [DW-1:0]   f_d0, f_d1;
  logic [NB-1:0]   f_m0, f_m1;

  // edges of the synced pin clocks
  assign k_rise  = s_q.kp[1] & ~s_q.kp_l;
  assign kn_rise = s_q.kn[1] & ~s_q.kn_l;
  // single clock mode launches on the input clocks
  assign o_rise  = s_q.scm[1] ? k_rise : (s_q.cp[1] & ~s_q.cp_l);
  assign on_rise = s_q.scm[1] ? kn_rise : (s_q.cn[1] & ~s_q.cn_l);
  // accesses only start on the positive input edge
  assign wr_start = k_rise & ~s_q.write_port_select_n[1];
  assign rd_take  = k_rise & ~s_q.read_port_select_n[1];
  assign ra       = s_q.a[1][MEM_AW-1:0];
  // second beat and write address close the write
  assign push     = s_q.wp & kn_rise;
  assign f_in     = {s_q.a[1][MEM_AW-1:0], s_q.d[1], s_q.byte_write_select_n[1], s_q.wd0, s_q.wm0};
  assign {f_idx, f_d1, f_m1, f_d0, f_m0} = f_out;
  // array port is busy during a read fetch, so the fifo stalls
  assign drain    = f_valid & ~rd_take;

  dsp_fifo #(
    .W     (EW),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_data_i   (f_in),
    .in_ready_o  (f_ready),
    .out_valid_o (f_valid),
    .out_data_o  (f_out),
    .out_ready_i (~rd_take)
  );

  // next state of the whole interface
  always_comb begin
    s_d = s_q;
    // two-flop synchronisers on every pin
    s_d.kp  = {s_q.kp[0], input_timing_pos_i};
    s_d.kn  = {s_q.kn[0], input_timing_neg_i};
    s_d.cp  = {s_q.cp[0], output_timing_pos_i};
    s_d.cn  = {s_q.cn[0], output_timing_neg_i};
    s_d.scm = {s_q.scm[0], single_clk_mode_i};
    s_d.pll = {s_q.pll[0], pll_disable_n_i};
    s_d.write_port_select_n = {s_q.write_port_select_n[0], write_port_select_n_i};
    s_d.read_port_select_n = {s_q.read_port_select_n[0], read_port_select_n_i};
    s_d.byte_write_select_n = {s_q.byte_write_select_n[0], byte_write_select_n_i};
    s_d.a   = {s_q.a[0], addr_i};
    s_d.d   = {s_q.d[0], d_i};
    // edge history reads only the second stage
    s_d.kp_l = s_q.kp[1];
    s_d.kn_l = s_q.kn[1];
    s_d.cp_l = s_q.cp[1];
    s_d.cn_l = s_q.cn[1];

    // write: beat0 with its mask on the pos edge
    if (wr_start) begin
      s_d.wp  = 1'h1;
      s_d.wd0 = s_q.d[1];
      s_d.wm0 = s_q.byte_write_select_n[1];
    end else if (kn_rise) begin
      // deselected port never arms, so data is ignored
      s_d.wp = 1'h0;
    end

    // drain one write burst into both arrays, lane by lane
    if (drain) begin
      for (int i = 0; i < NB; i++) begin
        if (!f_m0[i]) begin
          s_d.mem0[f_idx][i*LN +: LN] = f_d0[i*LN +: LN];
        end
        if (!f_m1[i]) begin
          s_d.mem1[f_idx][i*LN +: LN] = f_d1[i*LN +: LN];
        end
      end
    end

    // output sequencer, driven by output clock edges
    case (s_q.st)
      dsp_pkg::RD_BEAT0: begin
        if (on_rise) begin
          s_d.q  = s_q.hold1;
          s_d.st = dsp_pkg::RD_BEAT1;
        end
      end
      dsp_pkg::RD_IDLE,
      dsp_pkg::RD_WAIT,
      dsp_pkg::RD_BEAT1: begin
        if (o_rise) begin
          if (s_q.rdp_v && (s_q.lat == '0)) begin
            // a pending read completes unless a new take replaced it before its launch edge
            s_d.q     = s_q.rd0;
            s_d.hold1 = s_q.rd1;
            s_d.oe    = 1'h1;
            s_d.rdp_v = 1'h0;
            s_d.st    = dsp_pkg::RD_BEAT0;
          end else if (s_q.rdp_v) begin
            s_d.lat = LW'(s_q.lat - 1'h1);
            s_d.oe  = 1'h0;
            s_d.st  = dsp_pkg::RD_WAIT;
          end else begin
            // nothing left: release the data pins
            s_d.oe = 1'h0;
            s_d.st = dsp_pkg::RD_IDLE;
          end
        end
      end
      default: begin
        s_d.st = dsp_pkg::RD_IDLE;
      end
    endcase

    // read fetch after launch, so a new take wins over the clear
    if (rd_take) begin
      s_d.rdp_v = 1'h1;
      s_d.rd0   = s_q.mem0[ra];
      s_d.rd1   = s_q.mem1[ra];
      // legacy mode skips the extra launch edge
      s_d.lat   = s_q.pll[1] ? LW'(RD_LAT) : '0;
    end

    // echo follows the launching clock
    s_d.echo = s_q.scm[1] ? s_q.kp[1] : s_q.cp[1];
    s_d.wrdy = f_ready;
  end

  // single state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o           = s_q.q;
  assign q_oe_o        = s_q.oe;
  assign echo_timing_o = s_q.echo;
  assign wr_ready_o    = s_q.wrdy;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_wr_arm;
    wr_start |=> s_q.wp ##0 (s_q.wd0 == $past(s_q.d[1]));
  endproperty
  a_wr_arm: assert property (p_wr_arm) else $error("write beat0 not held");

  property p_wr_desel;
    (k_rise && s_q.write_port_select_n[1] && !s_q.wp) |=> !s_q.wp;
  endproperty
  a_wr_desel: assert property (p_wr_desel) else $error("deselected write armed");

  property p_push;
    // an empty fifo must show the pushed burst at its head, tagged with the neg-edge address
    (push && f_ready && !f_valid) |=> f_valid && (f_idx == $past(s_q.a[1][MEM_AW-1:0]));
  endproperty
  a_push: assert property (p_push) else $error("write address not from neg edge");

  property p_mask;
    (drain && f_m0[0]) |=> (s_q.mem0[$past(f_idx)][LN-1:0] == $past(s_q.mem0[f_idx][LN-1:0]));
  endproperty
  a_mask: assert property (p_mask) else $error("masked lane written");

  property p_rd_take;
    rd_take |=> s_q.rdp_v ##0 (s_q.rd1 == $past(s_q.mem1[ra]));
  endproperty
  a_rd_take: assert property (p_rd_take) else $error("read not taken");

  property p_beat1;
    (s_q.st == dsp_pkg::RD_BEAT0 && on_rise) |=> (q_o == $past(s_q.hold1)) && q_oe_o;
  endproperty
  a_beat1: assert property (p_beat1) else $error("second beat missing");

  property p_launch;
    $rose(q_oe_o) |-> $past(o_rise) && (s_q.st == dsp_pkg::RD_BEAT0);
  endproperty
  a_launch: assert property (p_launch) else $error("launch off output edge");

  property p_tristate;
    (o_rise && !s_q.rdp_v && s_q.st != dsp_pkg::RD_BEAT0) |=> !q_oe_o;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pins not released");

  property p_echo;
    // echo is the selected synced clock, one clk_i later
    echo_timing_o == $past(s_q.scm[1] ? s_q.kp[1] : s_q.cp[1]);
  endproperty
  a_echo: assert property (p_echo) else $error("echo off its clock");

  c_write: cover property (push ##[1:8] drain);
  c_read: cover property (rd_take ##[1:40] $rose(q_oe_o));
  c_burst: cover property ($rose(q_oe_o) ##[1:40] $fell(q_oe_o));
  c_both: cover property (rd_take && f_valid);
endmodule : dsp_iface

// file: dsp_defines.svh
// constants of the split-port ddr sram pin interface
// assumes: included by dsp_iface.sv, which holds all the logic
// Function
// - write data taken on both input edges
// - write select low starts write, high ignores
// - masked bytes stay unchanged in array
// - each byte select gates one nine-bit lane
// - mask sampled with its own data beat
// - read address on pos, write on neg
// - address width 22/21/20 by data width
// - address ignored when port deselected
// - read data launched on output clock edges (input clock edges in single clock mode)
// - outputs tristate when read port deselected
// - read select low starts read, high deselects
// - pending read finishes, then tristate after pos
// - each read returns a two-beat burst
// - storage is two half-depth arrays
// - every access starts on input pos edge
// - echo clock follows output pos clock (follows input pos clock in single clock mode)
// - pll off selects shorter legacy latency
`ifndef DSP_DEFINES_SVH
`define DSP_DEFINES_SVH
`define DSP_LANE_W 9
`define DSP_DW 36
`define DSP_DW_X9 9
`define DSP_DW_X18 18
`define DSP_AW_X9 22
`define DSP_AW_X18 21
`define DSP_AW_X36 20
`define DSP_MEM_AW 4
`define DSP_RD_LAT 1
`define DSP_FIFO_DEPTH 16
`endif

// file: dsp_pkg.sv
// types shared by the split-port ddr sram interface
// assumes: dsp_defines.svh sits in the include path
package dsp_pkg;
  // read output sequencer states
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_WAIT,
    RD_BEAT0,
    RD_BEAT1
  } dsp_rd_e;
endpackage : dsp_pkg

// file: dsp_ctl_model.sv
// controller model: pin clocks, selects, address, write data
// assumes: clk_i is the bench clock; pins change on its rising edge
`timescale 1ns/100ps
module dsp_ctl_model #(
  parameter int DW = 36,
  parameter int NB = 4,
  parameter int AW = 20
) (
  input  wire logic     clk_i,
  output logic          k_o,
  output logic          kn_o,
  output logic          c_o,
  output logic          cn_o,
  output logic          wsel_n_o,
  output logic          rsel_n_o,
  output logic [NB-1:0] bw_n_o,
  output logic [AW-1:0] addr_o,
  output logic [DW-1:0] d_o
);
  logic [4:0] ph_q;  // pin period phase, 32 bench cycles
  // k high on phase 0..15; c lags k by a quarter period
  assign k_o  = ~ph_q[4];
  assign kn_o = ph_q[4];
  assign c_o  = ph_q[4] ^ ph_q[3];
  assign cn_o = ~c_o;
  // quiet pins until the first slot
  initial begin
    ph_q     = 5'h00;
    wsel_n_o = 1'b1;
    rsel_n_o = 1'b1;
    bw_n_o   = '1;
    addr_o   = '0;
    d_o      = '0;
  end
  // free running phase counter
  always @(posedge clk_i) begin
    ph_q <= ph_q + 5'h01;
  end
  // one pin period; changes land 8 cycles clear of each k and kn edge, on the c and cn edges
  task automatic slot(input logic we, input logic re, input logic [AW-1:0] wa, input logic [AW-1:0] ra,
                      input logic [DW-1:0] d0, input logic [DW-1:0] d1,
                      input logic [NB-1:0] m0, input logic [NB-1:0] m1);
    while (ph_q != 5'h17) @(posedge clk_i);
    wsel_n_o <= ~we;
    rsel_n_o <= ~re;
    addr_o   <= ra;
    d_o      <= we ? d0 : ~d_o;
    bw_n_o   <= m0;
    @(posedge clk_i);
    while (ph_q != 5'h07) @(posedge clk_i);
    wsel_n_o <= 1'b1;
    rsel_n_o <= 1'b1;
    addr_o   <= wa;
    d_o      <= we ? d1 : ~d_o;
    bw_n_o   <= m1;
    @(posedge clk_i);
  endtask : slot
endmodule : dsp_ctl_model

// file: testbench.sv
// self-checking bench of the split-port ddr sram pin interface
// assumes: design files and the controller model are compiled first
`timescale 1ns/100ps
module testbench;
  localparam int DW = 36;
  localparam int NB = 4;
  localparam int AW = 20;
  // lanes 0 and 2 of a word; a masked lane keeps the older write
  localparam logic [DW-1:0] L02 = 36'h007FC01FF;
  localparam logic [DW-1:0] M0  = (36'h111111111 & L02) | (36'hEEEEEEEEE & ~L02);
  localparam logic [DW-1:0] M1  = (36'h222222222 & ~L02) | (36'hDDDDDDDDD & L02);
  logic          clk_i, rst_n_i, k, kn, c, cn, ws_n, rs_n;
  logic [NB-1:0] bw_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] d, q;
  logic          q_oe, echo, wr_rdy, single, pll_n;
  int            bad_count, compares, cyc;
  dsp_ctl_model #(.DW(DW), .NB(NB), .AW(AW)) i_ctl (.clk_i(clk_i), .k_o(k), .kn_o(kn), .c_o(c),
    .cn_o(cn), .wsel_n_o(ws_n), .rsel_n_o(rs_n), .bw_n_o(bw_n), .addr_o(addr), .d_o(d));
  dsp_iface #(.DW(DW)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .input_timing_pos_i(k),
    .input_timing_neg_i(kn), .output_timing_pos_i(c), .output_timing_neg_i(cn),
    .single_clk_mode_i(single), .pll_disable_n_i(pll_n), .write_port_select_n_i(ws_n),
    .read_port_select_n_i(rs_n), .byte_write_select_n_i(bw_n), .addr_i(addr), .d_i(d), .q_o(q),
    .q_oe_o(q_oe), .echo_timing_o(echo), .wr_ready_o(wr_rdy));
  always #2.5 clk_i = ~clk_i;
  // hang guard, far above the few thousand cycles the tests need
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // read, with a write alongside if we; checks delay window, both beats, release
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e0, e1, input int lo, hi,
                    input logic we = 1'b0, input logic [AW-1:0] wa = '0, input logic [DW-1:0] wd = '0);
    int n;
    n = 0;
    i_ctl.slot(we, 1'b1, wa, a, wd, ~wd, '0, '0);
    while (q_oe !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    check(DW'(n >= lo && n <= hi), DW'(1));
    repeat (8) @(posedge clk_i);
    check(q, e0);
    repeat (16) @(posedge clk_i);
    check(q, e1);
    repeat (40) @(posedge clk_i);
    check(DW'(q_oe), DW'(0));
  endtask : rd
  // echo follows c, or k in single mode; sample points tell the two apart
  task automatic echo_chk(input logic s);
    i_ctl.slot(1'b0, 1'b0, '0, '0, '0, '0, '1, '1);
    if (!s) repeat (16) @(posedge clk_i);
    check(DW'(echo), DW'(1));
    repeat (16) @(posedge clk_i);
    check(DW'(echo), DW'(0));
  endtask : echo_chk
  task automatic t_basic;
    i_ctl.slot(1'b1, 1'b0, 20'h00001, '0, 36'h123456789, 36'hABCDEF012, '0, '0);
    rd(20'h00001, 36'h123456789, 36'hABCDEF012, 30, 40, 1'b1, 20'h00002, 36'h0F0F0F0F0);
    rd(20'h00002, 36'h0F0F0F0F0, 36'hF0F0F0F0F, 30, 40);
    check(DW'(wr_rdy), DW'(1));
    $display("test basic done");
  endtask : t_basic
  task automatic t_mask;
    i_ctl.slot(1'b1, 1'b0, 20'h00005, '0, 36'h111111111, 36'h222222222, '0, '0);
    i_ctl.slot(1'b1, 1'b0, 20'h00005, '0, 36'hEEEEEEEEE, 36'hDDDDDDDDD, 4'h5, 4'hA);
    rd(20'h00005, M0, M1, 30, 40);
    $display("test mask done");
  endtask : t_mask
  // a deselected slot must neither drive the pins nor touch the array
  task automatic t_desel;
    i_ctl.slot(1'b0, 1'b0, 20'h00005, 20'h00005, '0, '0, '0, '0);
    repeat (80) @(posedge clk_i);
    check(DW'(q_oe), DW'(0));
    rd(20'h00005, M0, M1, 30, 40);
    $display("test deselect done");
  endtask : t_desel
  task automatic t_modes;
    pll_n <= 1'b0;
    rd(20'h00001, 36'h123456789, 36'hABCDEF012, 1, 8);
    pll_n  <= 1'b1;
    single <= 1'b1;
    rd(20'h00001, 36'h123456789, 36'hABCDEF012, 52, 64);
    echo_chk(1'b1);
    single <= 1'b0;
    echo_chk(1'b0);
    $display("test modes done");
  endtask : t_modes
  // write bursts back to back through the staging fifo, then reads with writes alongside
  task automatic t_stream;
    for (int i = 8; i < 12; i++) begin
      i_ctl.slot(1'b1, 1'b0, AW'(i), '0, {9{4'(i)}}, ~{9{4'(i)}}, '0, '0);
      check(DW'(wr_rdy), DW'(1));
    end
    for (int i = 8; i < 12; i++)
      rd(AW'(i), {9{4'(i)}}, ~{9{4'(i)}}, 30, 40, 1'b1, AW'(i + 4), DW'(i));
    for (int i = 12; i < 16; i++)
      rd(AW'(i), DW'(i - 4), ~DW'(i - 4), 30, 40);
    check(DW'(wr_rdy), DW'(1));
    check(DW'(q_oe), DW'(0));
    $display("test stream done");
  endtask : t_stream
  task automatic complete_run;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // reset, settle the pin clocks, then run the tests
  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    single = 1'b0;
    pll_n = 1'b1;
    {cyc, bad_count, compares} = '0;
    repeat (10) @(posedge clk_i);
    check(DW'(q_oe), DW'(0));
    check(q, '0);
    rst_n_i <= 1'b1;
    repeat (64) @(posedge clk_i);
    t_basic();
    t_mask();
    t_desel();
    t_modes();
    t_stream();
    complete_run();
  end
endmodule : testbench
